// [src/sbst_consts.vh]
// Behaviour
// [RULE1] 3-bit IR, bypass, 32-bit ID, 109-bit chain
// [RULE2] Code 000 external test, captures boundary cells
// [RULE3] Code 001 loads ID, memory undisturbed
// [RULE4] Code 010 samples, chain path, outputs floated
// [RULE5] Codes 011, 101, 110 have no function, act as bypass
// [RULE6] Code 100 samples, chain path, memory normal
// [RULE7] Code 111 selects bypass bit, memory normal
// [RULE8] ID: revision, part type, maker, bit0 one
// [RULE9] External test drives preloaded values on pins
// [RULE10] Chain bit 108 gates output bus in extest
// [RULE11] Bit 108 preset high at reset and TLR
// [RULE12] Standard TAP; sample rising, TDO falling
`ifndef SBST_CONSTS_VH
`define SBST_CONSTS_VH
`define SBST_IR_W      3
`define SBST_ID_W      32
`define SBST_BSR_W     109
`define SBST_OE_BIT    108
`define SBST_IR_EXTEST 3'h0
`define SBST_IR_IDCODE 3'h1
`define SBST_IR_SAMPZ  3'h2
`define SBST_IR_SAMPLE 3'h4
`define SBST_IR_BYPASS 3'h7
`define SBST_IR_CAPT   3'h1
`define SBST_REV_HI    31
`define SBST_REV_LO    29
`define SBST_PART_HI   28
`define SBST_PART_LO   12
`define SBST_MAKER_HI  11
`define SBST_MAKER_LO  1
`define SBST_SYNC_LO   2'h0
`define SBST_SYNC_HI   2'h3
// ==========
// TAP states
`define SBST_TLR  4'h0
`define SBST_RTI  4'h1
`define SBST_SDR  4'h2
`define SBST_CDR  4'h3
`define SBST_SHDR 4'h4
`define SBST_E1DR 4'h5
`define SBST_PDR  4'h6
`define SBST_E2DR 4'h7
`define SBST_UDR  4'h8
`define SBST_SIR  4'h9
`define SBST_CIR  4'ha
`define SBST_SHIR 4'hb
`define SBST_E1IR 4'hc
`define SBST_PIR  4'hd
`define SBST_E2IR 4'he
`define SBST_UIR  4'hf
`endif

// [src/sbst_tap_fsm.v]
`timescale 1ns/100ps
`include "sbst_consts.vh"
module sbst_tap_fsm (
    // Clock and reset
    input  wire       sys_clk,
    input  wire       rst_n,
    // Sampled link
    input  wire       tck_rise,
    input  wire       tms,
    // State
    output reg  [3:0] state
);
    reg [3:0] next_state;

    // =====================================
    // Sixteen-state controller
    // =====================================
    always @* begin
        case (state)
            `SBST_TLR:  next_state = tms ? `SBST_TLR  : `SBST_RTI;
            `SBST_RTI:  next_state = tms ? `SBST_SDR  : `SBST_RTI;
            `SBST_SDR:  next_state = tms ? `SBST_SIR  : `SBST_CDR;
            `SBST_CDR:  next_state = tms ? `SBST_E1DR : `SBST_SHDR;
            `SBST_SHDR: next_state = tms ? `SBST_E1DR : `SBST_SHDR;
            `SBST_E1DR: next_state = tms ? `SBST_UDR  : `SBST_PDR;
            `SBST_PDR:  next_state = tms ? `SBST_E2DR : `SBST_PDR;
            `SBST_E2DR: next_state = tms ? `SBST_UDR  : `SBST_SHDR;
            `SBST_UDR:  next_state = tms ? `SBST_SDR  : `SBST_RTI;
            `SBST_SIR:  next_state = tms ? `SBST_TLR  : `SBST_CIR;
            `SBST_CIR:  next_state = tms ? `SBST_E1IR : `SBST_SHIR;
            `SBST_SHIR: next_state = tms ? `SBST_E1IR : `SBST_SHIR;
            `SBST_E1IR: next_state = tms ? `SBST_UIR  : `SBST_PIR;
            `SBST_PIR:  next_state = tms ? `SBST_E2IR : `SBST_PIR;
            `SBST_E2IR: next_state = tms ? `SBST_UIR  : `SBST_SHIR;
            `SBST_UIR:  next_state = tms ? `SBST_SDR  : `SBST_RTI;
            default:    next_state = `SBST_TLR;
        endcase
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= `SBST_TLR;
        end else if (tck_rise) begin
            state <= next_state; // RULE12
        end
    end
endmodule // sbst_tap_fsm

// [src/sbst_tap.v]
`timescale 1ns/100ps
`include "sbst_consts.vh"
module sbst_tap #(
    parameter [2:0]  REVISION = 3'h0,       // Arbitrary value
    parameter [16:0] PART_ID  = 17'h00001,  // Arbitrary value
    parameter [10:0] MAKER_ID = 11'h001     // Arbitrary value
) (
    // Clock and reset
    input  wire                   sys_clk,
    input  wire                   rst_n,
    // Test link pins
    input  wire                   tck,
    input  wire                   tms,
    input  wire                   tdi,
    output reg                    tdo,
    output reg                    tdo_oe,
    // Boundary parallel capture from the device pins
    input  wire [`SBST_BSR_W-1:0] bsr_capture,
    // Boundary drive towards the pins
    output wire [`SBST_BSR_W-2:0] bsr_drive,
    output wire                   extest_sel,
    output wire                   q_bus_oe
);
    // =====================================
    // Pin synchronisers and edge detect
    // =====================================
    reg [1:0] tck_sync;
    reg [1:0] tms_sync;
    reg [1:0] tdi_sync;
    reg       tck_prev;
    wire      tck_rise;
    wire      tck_fall;

    // Memory pins reach the chain two clocks late, so they must stand
    // still for a few clocks around the capturing TCK edge
    reg  [`SBST_BSR_W-1:0] cap_meta;
    reg  [`SBST_BSR_W-1:0] cap_sync;

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tck_sync <= `SBST_SYNC_LO;
            tms_sync <= `SBST_SYNC_HI;
            tdi_sync <= `SBST_SYNC_HI;
            tck_prev <= 1'b0;
            cap_meta <= {`SBST_BSR_W{1'b0}};
            cap_sync <= {`SBST_BSR_W{1'b0}};
        end else begin
            tck_sync <= {tck_sync[0], tck};
            tms_sync <= {tms_sync[0], tms};
            tdi_sync <= {tdi_sync[0], tdi};
            tck_prev <= tck_sync[1];
            cap_meta <= bsr_capture;
            cap_sync <= cap_meta;
        end
    end

    assign tck_rise = tck_sync[1] & ~tck_prev;
    assign tck_fall = ~tck_sync[1] & tck_prev;

    // =====================================
    // Controller
    // =====================================
    wire [3:0] state;

    sbst_tap_fsm u_fsm (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .tck_rise (tck_rise),
        .tms      (tms_sync[1]),
        .state    (state)
    );

    // =====================================
    // Scan registers
    // =====================================
    reg  [`SBST_IR_W-1:0]  ir_shift; // RULE1
    reg  [`SBST_IR_W-1:0]  ir;
    reg                    bypass_bit;
    reg  [`SBST_ID_W-1:0]  id_shift;
    reg  [`SBST_BSR_W-1:0] bsr_shift;
    reg  [`SBST_BSR_W-1:0] bsr_upd;
    wire [`SBST_ID_W-1:0]  id_value;
    wire                   sel_id;
    wire                   sel_bsr;
    wire                   ser_out;
    wire                   in_tlr;
    reg  [`SBST_IR_W-1:0]  next_ir_shift;
    reg  [`SBST_IR_W-1:0]  next_ir;
    reg                    next_bypass_bit;
    reg  [`SBST_ID_W-1:0]  next_id_shift;
    reg  [`SBST_BSR_W-1:0] next_bsr_shift;
    reg  [`SBST_BSR_W-1:0] next_bsr_upd;

    // Codes that route the boundary chain between the serial pins
    function chain_code;
        input [`SBST_IR_W-1:0] code;
        begin
            chain_code = (code == `SBST_IR_EXTEST) || // RULE2
                         (code == `SBST_IR_SAMPZ)  || // RULE4
                         (code == `SBST_IR_SAMPLE);   // RULE6
        end
    endfunction

    assign id_value = {REVISION, PART_ID, MAKER_ID, 1'b1}; // RULE8
    assign in_tlr   = (state == `SBST_TLR);

    // Any code without a function falls back to bypass, a safe default
    assign sel_id  = (ir == `SBST_IR_IDCODE); // RULE3
    assign sel_bsr = chain_code(ir);

    // =====================================
    // Instruction register
    // =====================================
    always @* begin
        next_ir_shift = ir_shift;
        next_ir       = ir;
        if (in_tlr) begin
            // Held on every clock, not only at TCK, so a controller that
            // has just reached reset already shows the default code
            next_ir = `SBST_IR_IDCODE;
        end else if (tck_rise) begin
            case (state)
                `SBST_CIR: begin
                    next_ir_shift = `SBST_IR_CAPT;
                end
                `SBST_SHIR: begin
                    next_ir_shift = {tdi_sync[1],
                                     ir_shift[`SBST_IR_W-1:1]};
                end
                `SBST_UIR: begin
                    next_ir = ir_shift;
                end
                default: begin
                    next_ir = ir;
                end
            endcase
        end
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ir_shift <= `SBST_IR_CAPT;
            ir       <= `SBST_IR_IDCODE;
        end else begin
            ir_shift <= next_ir_shift;
            ir       <= next_ir;
        end
    end

    // =====================================
    // Data registers
    // =====================================
    always @* begin
        next_bypass_bit = bypass_bit;
        next_id_shift   = id_shift;
        next_bsr_shift  = bsr_shift;
        if (tck_rise) begin
            case (state)
                `SBST_CDR: begin
                    next_bypass_bit = 1'b0; // RULE7
                    if (sel_id) begin
                        next_id_shift = id_value; // RULE3
                    end
                    if (sel_bsr) begin
                        next_bsr_shift = cap_sync; // RULE2
                    end
                end
                `SBST_SHDR: begin
                    next_bypass_bit = tdi_sync[1];
                    next_id_shift   = {tdi_sync[1],
                                       id_shift[`SBST_ID_W-1:1]};
                    next_bsr_shift  = {tdi_sync[1],
                                       bsr_shift[`SBST_BSR_W-1:1]};
                end
                default: begin
                    next_bypass_bit = bypass_bit;
                end
            endcase
        end
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bypass_bit <= 1'b0;
            id_shift   <= {`SBST_ID_W{1'b0}};
            bsr_shift  <= {`SBST_BSR_W{1'b0}};
        end else begin
            bypass_bit <= next_bypass_bit;
            id_shift   <= next_id_shift;
            bsr_shift  <= next_bsr_shift;
        end
    end

    // =====================================
    // Boundary update stage
    // =====================================
    // Only a chain instruction may update, so pins stay put under ID scans
    always @* begin
        next_bsr_upd = bsr_upd;
        if (tck_rise && (state == `SBST_UDR) && sel_bsr) begin
            next_bsr_upd = bsr_shift; // RULE9
        end
        if (in_tlr) begin
            next_bsr_upd[`SBST_OE_BIT] = 1'b1; // RULE11
        end
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bsr_upd <= {1'b1, {(`SBST_BSR_W-1){1'b0}}}; // RULE11
        end else begin
            bsr_upd <= next_bsr_upd;
        end
    end

    // =====================================
    // Serial output, changed on falling TCK
    // =====================================
    assign ser_out = (state == `SBST_SHIR) ? ir_shift[0] :
                     sel_bsr ? bsr_shift[0] :
                     sel_id  ? id_shift[0] : bypass_bit; // RULE7

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tdo    <= 1'b0;
            tdo_oe <= 1'b0;
        end else if (tck_fall) begin
            tdo    <= ser_out; // RULE12
            tdo_oe <= (state == `SBST_SHIR) || (state == `SBST_SHDR);
        end
    end

    // =====================================
    // Effect on the memory pins
    // =====================================
    assign extest_sel = (ir == `SBST_IR_EXTEST); // RULE9
    assign bsr_drive  = bsr_upd[`SBST_BSR_W-2:0]; // RULE9
    // Sample-Z floats the bus; extest lets cell 108 decide
    assign q_bus_oe = (ir == `SBST_IR_SAMPZ) ? 1'b0 : // RULE4
                      extest_sel ? bsr_upd[`SBST_OE_BIT] : // RULE10
                      1'b1;
endmodule // sbst_tap

// [verif/sbst_tap_properties.sv]
`timescale 1ns/100ps
`include "sbst_consts.vh"
// ==========
// Port checker
module sbst_tap_properties (
    // Clock and reset
    input wire                   sys_clk,
    input wire                   rst_n,
    // Test link
    input wire                   tck,
    input wire                   tms,
    input wire                   tdi,
    input wire                   tdo,
    input wire                   tdo_oe,
    // Boundary
    input wire [`SBST_BSR_W-1:0] bsr_capture,
    input wire [`SBST_BSR_W-2:0] bsr_drive,
    input wire                   extest_sel,
    input wire                   q_bus_oe
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    reset_out_a: assert property (
        $rose(rst_n) |-> q_bus_oe && !extest_sel)
        else $error("bad output after reset");
    tdo_fall_a: assert property ($changed(tdo) |-> !$past(tck, 2))
        else $error("tdo moved off a falling tck");
    oe_fall_a: assert property ($changed(tdo_oe) |-> !$past(tck, 2))
        else $error("tdo_oe moved off a falling tck");
    tdo_hold_a: assert property (tck [*6] |=> $stable(tdo))
        else $error("tdo moved while tck high");
    oe_hold_a: assert property (tck [*6] |=> $stable(tdo_oe))
        else $error("tdo_oe moved while tck high");
    shift_sel_a: assert property (tdo_oe |-> $stable(extest_sel))
        else $error("extest_sel moved in shift");
    shift_qoe_a: assert property (tdo_oe |-> $stable(q_bus_oe))
        else $error("q_bus_oe moved in shift");
    shift_drv_a: assert property (tdo_oe |-> $stable(bsr_drive))
        else $error("bsr_drive moved in shift");
endmodule // sbst_tap_properties

bind sbst_tap sbst_tap_properties u_props (.sys_clk(sys_clk), .rst_n(rst_n),
    .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
    .bsr_capture(bsr_capture), .bsr_drive(bsr_drive),
    .extest_sel(extest_sel), .q_bus_oe(q_bus_oe));

// [verif/sbst_jtag_host.sv]
`timescale 1ns/100ps
// ==========
// Test controller model; tck runs only inside steps
module sbst_jtag_host (
    // Clock
    input  wire sys_clk,
    // Test link
    output reg  tck,
    output reg  tms,
    output reg  tdi,
    input  wire tdo
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end
    task step(input m, input d, output q);
        begin
            @(posedge sys_clk) #1;
            tms = m;
            tdi = d;
            repeat (7) @(posedge sys_clk);
            #1 tck = 1'b1;
            q = tdo;
            repeat (8) @(posedge sys_clk);
            #1 tck = 1'b0;
        end
    endtask
    task tap_reset;
        reg     q;
        integer i;
        begin
            for (i = 0; i < 6; i = i + 1)
                step(i < 5, 1'b0, q);
        end
    endtask
    // From idle: select, capture, n shifts LSB first, update, idle
    task scan(input ir, input integer n, input [108:0] din,
              output [108:0] dout);
        reg     q;
        integer i;
        begin
            dout = 0;
            step(1'b1, 1'b0, q);
            if (ir)
                step(1'b1, 1'b0, q);
            step(1'b0, 1'b0, q);
            step(1'b0, 1'b0, q);
            for (i = 0; i < n; i = i + 1) begin
                step(i == n - 1, din[i], q);
                dout[i] = q;
            end
            step(1'b1, 1'b0, q);
            step(1'b0, 1'b0, q);
        end
    endtask
endmodule // sbst_jtag_host

// [verif/testbench.sv]
`timescale 1ns/100ps
// ==========
// Testbench
module testbench;
    localparam [31:0]  ID_EXP = {3'h5, 17'h0a5a5, 11'h2b3, 1'b1};
    localparam [108:0] CAP    = {1'b1, {27{4'h9}}};
    localparam [108:0] PRE    = {1'b0, {27{4'h6}}};
    reg          sys_clk;
    reg          rst_n;
    reg  [108:0] bsr_capture;
    reg  [108:0] got;
    wire         tck, tms, tdi, tdo;
    wire [107:0] bsr_drive;
    wire         extest_sel, q_bus_oe, tdo_oe;
    integer      miscompares, cmp_count, cycles;
    integer      oe_hits = 0;
    // Identity values are arbitrary
    sbst_tap #(.REVISION(3'h5), .PART_ID(17'h0a5a5), .MAKER_ID(11'h2b3))
    u_sbst_tap (.sys_clk(sys_clk), .rst_n(rst_n), .tck(tck), .tms(tms),
        .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .bsr_capture(bsr_capture),
        .bsr_drive(bsr_drive), .extest_sel(extest_sel),
        .q_bus_oe(q_bus_oe));
    sbst_jtag_host ctl (.sys_clk(sys_clk), .tck(tck), .tms(tms),
        .tdi(tdi), .tdo(tdo));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // Shift cycles seen at the link, for the output-enable checks
    always @(posedge tck) begin
        if (tdo_oe === 1'b1)
            oe_hits = oe_hits + 1;
    end
    task chk(input [108:0] seen, input [108:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp) begin
                miscompares = miscompares + 1;
                $display("[ERR] %0t got %h exp %h", $time, seen, exp);
            end
        end
    endtask
    task complete_run;
        begin
            if (miscompares == 0 && cmp_count > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    always @(posedge sys_clk) begin
        cycles = cycles + 1;
        if (cycles == 40000) begin
            miscompares = miscompares + 1;
            complete_run;
        end
    end
    // Only defined codes are loaded
    task load_ir(input [2:0] c);
        integer n0;
        begin
            n0 = oe_hits;
            ctl.scan(1'b1, 3, {106'h0, c}, got);
            chk(got[2:0], 3'h1);
            chk(oe_hits - n0, 3);
        end
    endtask
    task t_idcode;
        begin
            chk({extest_sel, q_bus_oe}, 2'b01);
            ctl.tap_reset;
            ctl.scan(1'b0, 32, 0, got);
            chk(got[31:0], ID_EXP);
            load_ir(3'h1);
            ctl.scan(1'b0, 32, 0, got);
            chk(got[31:0], ID_EXP);
        end
    endtask
    task t_bypass;
        integer n0;
        begin
            load_ir(3'h7);
            n0 = oe_hits;
            ctl.scan(1'b0, 2, 1, got);
            chk(got[1:0], 2'b10);
            chk(oe_hits - n0, 2);
            chk(tdo_oe, 1'b0);
            chk({extest_sel, q_bus_oe}, 2'b01);
        end
    endtask
    task t_extest;
        begin
            load_ir(3'h4);
            ctl.scan(1'b0, 109, PRE, got);
            chk(got, CAP);
            chk(bsr_drive, PRE[107:0]);
            load_ir(3'h0);
            chk({extest_sel, q_bus_oe}, 2'b10);
            ctl.scan(1'b0, 109, CAP, got);
            chk(got, CAP);
            chk({q_bus_oe, bsr_drive}, CAP);
            ctl.scan(1'b0, 109, PRE, got);
            chk(q_bus_oe, 1'b0);
            ctl.tap_reset;
            chk({extest_sel, q_bus_oe}, 2'b01);
            load_ir(3'h0);
            chk({extest_sel, q_bus_oe}, 2'b11);
        end
    endtask
    task t_sampz;
        begin
            bsr_capture = ~CAP;
            load_ir(3'h2);
            chk({extest_sel, q_bus_oe}, 2'b00);
            ctl.scan(1'b0, 109, PRE, got);
            chk(got, ~CAP);
        end
    endtask
    initial begin
        rst_n = 1'b0;
        bsr_capture = CAP;
        miscompares = 0;
        cmp_count = 0;
        cycles = 0;
        repeat (8) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        repeat (3) @(posedge sys_clk);
        t_idcode;
        t_bypass;
        t_extest;
        t_sampz;
        complete_run;
    end
endmodule // testbench
